//--- verilog/adc_cfg_defines.svh
// Offsets, field positions, reset values and timing counts of the
// channel configuration and rate control block.
// Assumes byte addressing on a 32-bit AXI4-Lite register bus.
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CH_INPUT_BASE 8'h00
`define CH_CONFIG_BASE 8'h20
`define CONTROL_OFS 8'h40
`define GPIO_DIR_OFS 8'h44
`define GPIO_OUT_OFS 8'h48
`define GPIO_IN_OFS 8'h4c
`define STATUS_OFS 8'h50
`define CAL_OFFSET_BASE 8'h60
`define CAL_GAIN_BASE 8'h70

// ----------------------------------------
// Field positions
// ----------------------------------------
`define INP_NEG_LSB 0
`define INP_POS_LSB 3
`define INP_REF_BIT 6
`define CFG_BUF_BIT 0
`define CFG_GAIN_LSB 1
`define CFG_RATE_LSB 4
`define CTL_CLK_LSB 0
`define CTL_BGCAL_LSB 2
`define CTL_FIRST_LSB 4
`define CTL_LAST_LSB 7
`define CTL_RUN_BIT 10

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define INP_RESET 7'h00
`define CFG_RESET 7'h70
`define CONTROL_RESET 11'h000
`define GAIN_COEF_RESET 16'h8000
`define OFFSET_COEF_RESET 16'h0000
`define CLK_INTERNAL 2'h0
`define CLK_EXTERNAL 2'h1
`define CLK_DETECT 2'h2
`define NUM_CH 7
`define NUM_CAL_CH 4
`define LAST_CH 3'h6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// Timing counts in converter clock ticks
// ----------------------------------------
`define SLOW_BASE_TICKS 266240
`define FAST_BASE_TICKS 16640
`define FILTER_CLK_DIV 256
`define FILTER_REF_FREQ 13952

`endif

//--- verilog/adc_cfg_pkg.sv
// Types shared by the channel configuration and rate control block.
// Assumes adc_cfg_defines.svh is compiled alongside.
package adc_cfg_pkg;

  // ----------------------------------------
  // Conversion sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SETUP = 2'h1,
    ST_CONVERT = 2'h3,
    ST_DONE = 2'h2
  } conv_state_e;

  // ----------------------------------------
  // Background calibration modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    BGCAL_OFF = 2'h0,
    BGCAL_OFS_CORR_GAIN_EST = 2'h1,
    BGCAL_OFS_CORR_GAIN_CORR = 2'h2,
    BGCAL_OFS_EST_GAIN_EST = 2'h3
  } bgcal_mode_e;

  // ----------------------------------------
  // Per-channel register state
  // ----------------------------------------
  typedef struct packed {
    logic [6:0] channel_input_control;
    logic [6:0] channel_configuration;
  } slot_s;

endpackage

//--- verilog/channel_config_slot.sv
// One channel's input control and configuration registers.
// Assumes writes arrive already decoded and byte-lane gated.
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

module channel_config_slot (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic wr_input,
  input wire logic wr_config,
  input wire logic [6:0] wr_data,
  // Stored settings
  output logic [6:0] channel_input_control,
  output logic [6:0] channel_configuration
);

  adc_cfg_pkg::slot_s slot_reg;
  adc_cfg_pkg::slot_s slot_next;

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_comb begin
    slot_next = slot_reg;
    if (wr_input) begin
      slot_next.channel_input_control = wr_data;
    end
    if (wr_config) begin
      slot_next.channel_configuration = wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_reg.channel_input_control <= `INP_RESET;
      slot_reg.channel_configuration <= `CFG_RESET;
    end else begin
      slot_reg <= slot_next;
    end
  end

  assign channel_input_control = slot_reg.channel_input_control;
  assign channel_configuration = slot_reg.channel_configuration;

endmodule

//--- verilog/adc_channel_config_control.sv
// Channel configuration, rate sequencing, clock choice, GPIO and
// background calibration for a multichannel sigma-delta front end.
// Assumes conv_tick is a one-cycle pulse per converter clock period,
// made on aclk; raw_code and calibration inputs come from aclk logic.
//
// Function
// - Per-channel reference select, first after reset
// - Positive and negative input index selectors
// - Four differential or seven single-ended channels
// - Gain is fixed stage times programmable stage
// - Gain field held per channel
// - Buffer forced at gain sixteen or more
// - Clock source choice, crystal detect stops oscillator
// - Eight rates, default fastest
// - External clock rates: divide by base counts
// - Rate selectable per channel
// - Scanned rate divides by channel count
// - Mains rejection only at slow rates
// - Filter response scales with converter clock
// - Seven GPIO pins drive or read levels
// - Offset and gain correction applied only while background calibration is on
// - Background calibration on channels zero to three
// - Four background calibration modes
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

module adc_channel_config_control #(
  parameter int SLOW_BASE_TICKS = `SLOW_BASE_TICKS,
  parameter int FAST_BASE_TICKS = `FAST_BASE_TICKS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter clocking
  input wire logic conv_tick,
  input wire logic crystal_present,
  output logic internal_osc_enable,
  output logic external_clk_select,
  // Analog front end settings
  output logic second_reference,
  output logic [2:0] positive_input_select,
  output logic [2:0] negative_input_select,
  output logic fixed_gain_stage,
  output logic [1:0] programmable_gain_stage,
  output logic unity_input_buffer,
  output logic [2:0] output_rate_select,
  output logic mains_rejection,
  output logic sample_start,
  // Background calibration
  input wire logic [15:0] cal_offset_meas,
  input wire logic [15:0] cal_gain_meas,
  input wire logic cal_meas_valid,
  output logic bgcal_active,
  // Conversion result
  input wire logic [15:0] raw_code,
  output logic [15:0] result_code,
  output logic [2:0] result_channel,
  output logic result_valid,
  // General purpose pins
  input wire logic [6:0] general_purpose_pins_in,
  output logic [6:0] general_purpose_pins_out,
  output logic [6:0] general_purpose_pins_oe
);

  generate
    if (SLOW_BASE_TICKS < 1 || SLOW_BASE_TICKS * 8 >= (1 << 22) ||
        FAST_BASE_TICKS < 1 || FAST_BASE_TICKS > SLOW_BASE_TICKS) begin : g_bad
      $error("Base tick counts out of range");
    end
  endgenerate

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [10:0] control;
    logic [6:0] gpio_dir;
    logic [6:0] gpio_out;
    logic [6:0] gpio_s1;
    logic [6:0] gpio_s2;
    logic xtal_s1;
    logic xtal_s2;
    adc_cfg_pkg::conv_state_e state;
    logic [2:0] cur_ch;
    logic [21:0] tick_cnt;
    logic [21:0] tick_target;
    logic ref_sel;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic fga_on;
    logic [1:0] pga_code;
    logic buf_on;
    logic [2:0] rate_sel;
    logic mains_on;
    logic cal_on;
    logic start;
    logic [3:0][15:0] offset_coef;
    logic [3:0][15:0] gain_coef;
    logic [15:0] result;
    logic [2:0] result_ch;
    logic result_strobe;
    logic osc_on;
    logic ext_sel;
  } top_s;

  top_s r_reg;
  top_s r_next;

  logic [6:0] inp_q [`NUM_CH];
  logic [6:0] cfg_q [`NUM_CH];
  logic [6:0] wr_input_en;
  logic [6:0] wr_config_en;
  logic do_write;

  // ----------------------------------------
  // Per-channel registers
  // ----------------------------------------
  generate
    for (genvar i = 0; i < `NUM_CH; i++) begin : g_slot
      assign wr_input_en[i] = do_write && r_reg.wstrb[0] &&
                              r_reg.awaddr == `CH_INPUT_BASE + 8'(4 * i);
      assign wr_config_en[i] = do_write && r_reg.wstrb[0] &&
                               r_reg.awaddr == `CH_CONFIG_BASE + 8'(4 * i);
      channel_config_slot u_slot (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_input(wr_input_en[i]),
        .wr_config(wr_config_en[i]),
        .wr_data(r_reg.wdata[6:0]),
        .channel_input_control(inp_q[i]),
        .channel_configuration(cfg_q[i])
      );
    end
  endgenerate

  assign do_write = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 &&
           ((a < `CH_INPUT_BASE + 8'h1c) ||
            (a >= `CH_CONFIG_BASE && a < `CH_CONFIG_BASE + 8'h1c) ||
            (a >= `CONTROL_OFS && a <= `STATUS_OFS) ||
            (a >= `CAL_OFFSET_BASE && a < `CAL_GAIN_BASE + 8'h10));
  endfunction

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  logic [2:0] first_ch;
  logic [2:0] last_ch;
  logic [2:0] scan_n;
  logic ref_conflict;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [7:0] ra;
  logic [6:0] nxt_inp;
  logic [6:0] nxt_cfg;
  logic [2:0] gsel;
  logic [1:0] shift_n;
  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic signed [33:0] scaled;
  logic [15:0] corrected;
  logic [2:0] next_ch;

  always_comb begin
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.result_strobe = 1'b0;
    first_ch = r_reg.control[`CTL_FIRST_LSB +: 3];
    last_ch = r_reg.control[`CTL_LAST_LSB +: 3];
    if (first_ch > `LAST_CH) begin
      first_ch = `LAST_CH;
    end
    if (last_ch > `LAST_CH || last_ch < first_ch) begin
      last_ch = first_ch;
    end
    scan_n = last_ch - first_ch + 3'h1;
    next_ch = (r_reg.cur_ch >= last_ch) ? first_ch : r_reg.cur_ch + 3'h1;
    ref_conflict = 1'b0;
    for (int c = 0; c < `NUM_CH; c++) begin
      if (inp_q[c][`INP_REF_BIT] && (inp_q[c][`INP_POS_LSB +: 3] >= 3'h6 ||
          inp_q[c][`INP_NEG_LSB +: 3] >= 3'h6)) begin
        ref_conflict = 1'b1;
      end
    end
    status_word = {21'h0, ref_conflict, scan_n, r_reg.state != adc_cfg_pkg::ST_IDLE,
                   r_reg.cur_ch, r_reg.ext_sel, r_reg.osc_on, r_reg.xtal_s2};

    // Synchronisers
    r_next.gpio_s1 = general_purpose_pins_in;
    r_next.gpio_s2 = r_reg.gpio_s1;
    r_next.xtal_s1 = crystal_present;
    r_next.xtal_s2 = r_reg.xtal_s1;

    // Clock source selection
    case (r_reg.control[`CTL_CLK_LSB +: 2])
      `CLK_EXTERNAL: r_next.ext_sel = 1'b1;
      `CLK_DETECT: r_next.ext_sel = r_reg.xtal_s2;
      default: r_next.ext_sel = 1'b0;
    endcase
    r_next.osc_on = !r_next.ext_sel;

    // AXI write channel
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_held = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_held = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (do_write) begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = is_mapped(r_reg.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (r_reg.awaddr)
        `CONTROL_OFS: r_next.control =
          11'(merge({21'h0, r_reg.control}, r_reg.wdata, r_reg.wstrb));
        `GPIO_DIR_OFS: r_next.gpio_dir =
          7'(merge({25'h0, r_reg.gpio_dir}, r_reg.wdata, r_reg.wstrb));
        `GPIO_OUT_OFS: r_next.gpio_out =
          7'(merge({25'h0, r_reg.gpio_out}, r_reg.wdata, r_reg.wstrb));
        default: ;
      endcase
    end
    r_next.awready = !r_next.aw_held && !r_next.bvalid;
    r_next.wready = !r_next.w_held && !r_next.bvalid;

    // AXI read channel
    ra = s_axi_araddr;
    rd_word = 32'h0;
    if (ra < `CH_INPUT_BASE + 8'h1c) begin
      rd_word = {25'h0, inp_q[3'(ra[4:2])]};
    end else if (ra >= `CH_CONFIG_BASE && ra < `CH_CONFIG_BASE + 8'h1c) begin
      rd_word = {25'h0, cfg_q[3'(ra[4:2])]};
    end else if (ra >= `CAL_OFFSET_BASE && ra < `CAL_GAIN_BASE) begin
      rd_word = {16'h0, r_reg.offset_coef[ra[3:2]]};
    end else if (ra >= `CAL_GAIN_BASE && ra < `CAL_GAIN_BASE + 8'h10) begin
      rd_word = {16'h0, r_reg.gain_coef[ra[3:2]]};
    end else begin
      case (ra)
        `CONTROL_OFS: rd_word = {21'h0, r_reg.control};
        `GPIO_DIR_OFS: rd_word = {25'h0, r_reg.gpio_dir};
        `GPIO_OUT_OFS: rd_word = {25'h0, r_reg.gpio_out};
        `GPIO_IN_OFS: rd_word = {25'h0, r_reg.gpio_s2};
        `STATUS_OFS: rd_word = status_word;
        default: rd_word = 32'h0;
      endcase
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rdata = is_mapped(ra) ? rd_word : 32'h0;
      r_next.rresp = is_mapped(ra) ? `RESP_OKAY : `RESP_SLVERR;
    end
    r_next.arready = !r_next.rvalid;

    // Background calibration coefficient tracking
    if (cal_meas_valid && r_reg.cal_on && r_reg.state == adc_cfg_pkg::ST_CONVERT) begin
      case (adc_cfg_pkg::bgcal_mode_e'(r_reg.control[`CTL_BGCAL_LSB +: 2]))
        adc_cfg_pkg::BGCAL_OFS_CORR_GAIN_EST: begin
          r_next.offset_coef[r_reg.cur_ch[1:0]] = cal_offset_meas;
        end
        adc_cfg_pkg::BGCAL_OFS_CORR_GAIN_CORR: begin
          r_next.offset_coef[r_reg.cur_ch[1:0]] = cal_offset_meas;
          r_next.gain_coef[r_reg.cur_ch[1:0]] = cal_gain_meas;
        end
        default: ;
      endcase
    end

    // Output code correction
    diff = $signed({raw_code[15], raw_code}) -
           $signed({r_reg.offset_coef[r_reg.cur_ch[1:0]][15],
                    r_reg.offset_coef[r_reg.cur_ch[1:0]]});
    prod = diff * $signed({1'b0, r_reg.gain_coef[r_reg.cur_ch[1:0]]});
    scaled = prod >>> 15;
    if (scaled > 34'sd32767) begin
      corrected = 16'h7fff;
    end else if (scaled < -34'sd32768) begin
      corrected = 16'h8000;
    end else begin
      corrected = scaled[15:0];
    end

    // Conversion sequencer
    nxt_inp = inp_q[r_reg.cur_ch];
    nxt_cfg = cfg_q[r_reg.cur_ch];
    gsel = nxt_cfg[`CFG_GAIN_LSB +: 3];
    shift_n = 2'h3 - nxt_cfg[`CFG_RATE_LSB +: 2];
    case (r_reg.state)
      adc_cfg_pkg::ST_IDLE: begin
        if (r_reg.control[`CTL_RUN_BIT]) begin
          r_next.cur_ch = first_ch;
          r_next.state = adc_cfg_pkg::ST_SETUP;
        end
      end
      adc_cfg_pkg::ST_SETUP: begin
        r_next.ref_sel = nxt_inp[`INP_REF_BIT];
        r_next.pos_sel = nxt_inp[`INP_POS_LSB +: 3];
        r_next.neg_sel = nxt_inp[`INP_NEG_LSB +: 3];
        r_next.fga_on = gsel[2];
        r_next.pga_code = gsel[1:0];
        r_next.buf_on = gsel[2] | nxt_cfg[`CFG_BUF_BIT];
        r_next.rate_sel = nxt_cfg[`CFG_RATE_LSB +: 3];
        r_next.mains_on = !nxt_cfg[`CFG_RATE_LSB + 2];
        r_next.cal_on = r_reg.cur_ch < 3'(`NUM_CAL_CH) &&
                        r_reg.control[`CTL_BGCAL_LSB +: 2] != 2'h0;
        r_next.tick_target = nxt_cfg[`CFG_RATE_LSB + 2] ?
          22'(FAST_BASE_TICKS) << shift_n :
          22'(SLOW_BASE_TICKS) << shift_n;
        r_next.tick_cnt = 22'h0;
        r_next.start = 1'b1;
        r_next.state = adc_cfg_pkg::ST_CONVERT;
      end
      adc_cfg_pkg::ST_CONVERT: begin
        if (conv_tick) begin
          r_next.tick_cnt = r_reg.tick_cnt + 22'h1;
          if (r_reg.tick_cnt + 22'h1 >= r_reg.tick_target) begin
            r_next.state = adc_cfg_pkg::ST_DONE;
          end
        end
      end
      adc_cfg_pkg::ST_DONE: begin
        r_next.result = r_reg.cal_on ? corrected : raw_code;
        r_next.result_ch = r_reg.cur_ch;
        r_next.result_strobe = 1'b1;
        r_next.cur_ch = next_ch;
        r_next.state = r_reg.control[`CTL_RUN_BIT] ? adc_cfg_pkg::ST_SETUP :
                       adc_cfg_pkg::ST_IDLE;
      end
      default: r_next.state = adc_cfg_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.control <= `CONTROL_RESET;
      r_reg.state <= adc_cfg_pkg::ST_IDLE;
      r_reg.offset_coef <= {4{`OFFSET_COEF_RESET}};
      r_reg.gain_coef <= {4{`GAIN_COEF_RESET}};
      r_reg.osc_on <= 1'b1;
      r_reg.rate_sel <= 3'h7;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign internal_osc_enable = r_reg.osc_on;
  assign external_clk_select = r_reg.ext_sel;
  assign second_reference = r_reg.ref_sel;
  assign positive_input_select = r_reg.pos_sel;
  assign negative_input_select = r_reg.neg_sel;
  assign fixed_gain_stage = r_reg.fga_on;
  assign programmable_gain_stage = r_reg.pga_code;
  assign unity_input_buffer = r_reg.buf_on;
  assign output_rate_select = r_reg.rate_sel;
  assign mains_rejection = r_reg.mains_on;
  assign sample_start = r_reg.start;
  assign bgcal_active = r_reg.cal_on;
  assign result_code = r_reg.result;
  assign result_channel = r_reg.result_ch;
  assign result_valid = r_reg.result_strobe;
  assign general_purpose_pins_out = r_reg.gpio_out;
  assign general_purpose_pins_oe = r_reg.gpio_dir;

endmodule

//--- dv/adc_cfg_props.sv
// Checker: relations between the control block outputs over time.
// Assumes it is bound onto adc_channel_config_control.
`timescale 1ns/1ps
module adc_cfg_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic sample_start,
  input wire logic result_valid,
  input wire logic [2:0] result_channel,
  input wire logic second_reference,
  input wire logic [2:0] positive_input_select,
  input wire logic [2:0] output_rate_select,
  input wire logic fixed_gain_stage,
  input wire logic unity_input_buffer,
  input wire logic mains_rejection,
  input wire logic external_clk_select,
  input wire logic internal_osc_enable,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_start_once;
    sample_start ##1 !sample_start;
  endsequence
  sequence s_result_once;
    result_valid ##1 !result_valid;
  endsequence
  a_buf_forced: assert property (fixed_gain_stage |-> unity_input_buffer)
    else $error("buffer left out at high gain");
  a_mains_slow: assert property (mains_rejection == !output_rate_select[2])
    else $error("mains rejection wrong for rate");
  a_set_at_start: assert property ($changed({second_reference,
    positive_input_select, output_rate_select, fixed_gain_stage}) |-> sample_start)
    else $error("settings changed outside a start");
  a_start_pulse: assert property (sample_start |-> s_start_once)
    else $error("start pulse too long");
  a_result_pulse: assert property (result_valid |-> s_result_once)
    else $error("result pulse too long");
  a_osc_off_ext: assert property (external_clk_select |-> !internal_osc_enable)
    else $error("oscillator left on with external clock");
  a_result_chan: assert property (result_valid |-> result_channel <= 3'h6)
    else $error("result channel out of range");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule
bind adc_channel_config_control adc_cfg_props adc_cfg_props_i (.*);

//--- dv/sensor_model.sv
// Sensor side model: converter tick, filter code, calibration measures.
// Assumes the block under test runs on the same aclk.
`timescale 1ns/1ps
module sensor_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // From the block
  input wire logic sample_start,
  input wire logic [2:0] positive_input_select,
  input wire logic [2:0] negative_input_select,
  // To the block
  output logic conv_tick = 1'b0,
  output logic [15:0] raw_code = 16'h0000,
  output logic [15:0] cal_offset_meas,
  output logic [15:0] cal_gain_meas,
  output logic cal_meas_valid = 1'b0
);
  assign cal_offset_meas = 16'h0001;
  assign cal_gain_meas = 16'h8000;
  always @(posedge aclk) begin
    conv_tick <= aresetn && !conv_tick;
    cal_meas_valid <= aresetn && sample_start;
    if (sample_start) begin
      raw_code <= {8'ha5, 2'h0, positive_input_select, negative_input_select};
    end
  end
endmodule

//--- dv/testbench.sv
// Bench: register tasks over AXI4-Lite, scanned conversions, pins.
// Assumes the sensor model supplies ticks and codes.
`timescale 1ns/1ps
module testbench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, crystal_present = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, programmable_gain_stage;
  logic conv_tick, internal_osc_enable, external_clk_select, second_reference;
  logic fixed_gain_stage, unity_input_buffer, mains_rejection, sample_start;
  logic [2:0] positive_input_select, negative_input_select, output_rate_select, result_channel;
  logic [15:0] cal_offset_meas, cal_gain_meas, raw_code, result_code, ex;
  logic cal_meas_valid, bgcal_active, result_valid;
  logic [6:0] gp_ext = 7'h2a, general_purpose_pins_in;
  logic [6:0] general_purpose_pins_out, general_purpose_pins_oe;
  logic [6:0] cin [7], ccf [7];
  logic [3:0] clk_tab [5] = '{4'h1, 4'h4, 4'h9, 4'ha, 4'hf};
  int failures = 0, tests_run = 0, n_res = 0, s_ch = 0, r_ch = 0, tk = 0, tg = 0, bg = 0;
  assign general_purpose_pins_in = (general_purpose_pins_oe & general_purpose_pins_out)
    | (~general_purpose_pins_oe & gp_ext);
  adc_channel_config_control #(.SLOW_BASE_TICKS(16), .FAST_BASE_TICKS(4))
    adc_channel_config_control_i (.*);
  sensor_model sensor_model_i (.*);
  initial begin
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Conversion monitor
  // ----------------------------------------
  always @(posedge aclk) begin
    if (conv_tick) tk++;
    if (sample_start) begin
      chk("ref", second_reference, cin[s_ch][6]);
      chk("inputs", {positive_input_select, negative_input_select}, cin[s_ch][5:0]);
      chk("gain", {fixed_gain_stage, programmable_gain_stage}, ccf[s_ch][3:1]);
      chk("buffer", unity_input_buffer, ccf[s_ch][0] | ccf[s_ch][3]);
      chk("rate", output_rate_select, ccf[s_ch][6:4]);
      chk("mains", mains_rejection, !ccf[s_ch][6]);
      chk("bgcal", bgcal_active, bg != 0 && s_ch < 4);
      tk = 0;
      s_ch = (s_ch + 1) % 7;
    end
    if (result_valid) begin
      ex = {8'ha5, 2'h0, cin[r_ch][5:0]} - 16'(bg != 0 && r_ch < 4);
      tg = (ccf[r_ch][6] ? 4 : 16) << (3 - ccf[r_ch][5:4]);
      chk("code", result_code, ex);
      chk("channel", result_channel, r_ch);
      chk("ticks", tk + 1 >= tg && tk <= tg + 1, 1);
      r_ch = (r_ch + 1) % 7;
      n_res++;
    end
  end
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    #400000;
    failures++;
    stop_test;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, d, r);
    chk("input reset", d, 0);
    rd(8'h20, d, r);
    chk("config reset", d, 32'h70);
    rd(8'h1c, d, r);
    chk("unmapped resp", r, 2);
    wr(8'h02, 0, r);
    chk("misaligned resp", r, 2);
    for (int t = 0; t < 5; t++) begin
      crystal_present <= clk_tab[t][1];
      wr(8'h40, clk_tab[t][3:2], r);
      repeat (6) @(posedge aclk);
      chk("osc", internal_osc_enable, clk_tab[t][0]);
    end
    wr(8'h44, 32'h0f, r);
    wr(8'h48, 32'h05, r);
    repeat (6) @(posedge aclk);
    chk("pin dir", general_purpose_pins_oe, 32'h0f);
    chk("pin out", general_purpose_pins_out, 32'h05);
    rd(8'h4c, d, r);
    chk("pin level", d, 32'h25);
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 7; i++) begin
        cin[i] = {p == 1 && i == 1, 3'((i + 4) % 6), 3'((i + 1) % 6)};
        ccf[i] = {3'((i + p) % 8), 3'((i + p) % 8), 1'(i % 2)};
        wr(8'(4 * i), {25'h0, cin[i]}, r);
        wr(8'(32 + 4 * i), {25'h0, ccf[i]}, r);
      end
      bg = p ^ (p >> 1);
      s_ch = 0;
      r_ch = 0;
      n_res = 0;
      wr(8'h40, 32'h700 | bg << 2, r);
      rd(8'h50, d, r);
      chk("scan count", d[9:7], 7);
      chk("ref conflict", d[10], 0);
      for (int n = 0; n < 9000 && n_res < 7; n++) @(posedge aclk);
      chk("results", n_res, 7);
      wr(8'h40, bg << 2, r);
      for (int n = 0; n < 300; n++) begin
        rd(8'h50, d, r);
        if (!d[6]) break;
      end
      chk("idle", d[6], 0);
    end
    rd(8'h60, d, r);
    chk("offset coef", d, 1);
    stop_test;
  end
endmodule
